// ==== test/dac_cfg_checker_asserts.sv ====
// port assertions for the converter configuration bank
// assumes one clock domain and the bench holding select low 8 mclk past the last bit
`timescale 1ns/1ps
module dac_cfg_checker (
    input wire        mclk,
    input wire        nrst,
    input wire        sif_sen_n,
    input wire        sync_in,
    input wire        converter_clk_lost,
    input wire        data_clk_lost,
    input wire        fifo_collision,
    input wire        outputs_on,
    input wire        offset_ab_resync,
    input wire        offset_cd_resync,
    input wire        corr_ab_resync,
    input wire        corr_cd_resync,
    input wire        mixer_ab_resync,
    input wire        mixer_cd_resync,
    input wire        nco_acc_resync,
    input wire        pll_ndiv_reset,
    input wire        pll_enable,
    input wire [31:0] osc_freq_word_ab,
    input wire [31:0] osc_freq_word_cd,
    input wire [15:0] osc_phase_ab,
    input wire [15:0] osc_phase_cd
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_ofs_ab; offset_ab_resync |-> !sif_sen_n ##1 !offset_ab_resync; endproperty
    a_ofs_ab: assert property (p_ofs_ab) else $error("offset ab resync bad");
    property p_ofs_cd; offset_cd_resync |-> !sif_sen_n ##1 !offset_cd_resync; endproperty
    a_ofs_cd: assert property (p_ofs_cd) else $error("offset cd resync bad");
    property p_cor_ab; corr_ab_resync |=> !corr_ab_resync; endproperty
    a_cor_ab: assert property (p_cor_ab) else $error("corr ab resync bad");
    property p_cor_cd; corr_cd_resync |=> !corr_cd_resync; endproperty
    a_cor_cd: assert property (p_cor_cd) else $error("corr cd resync bad");
    // the pulse leads the phase copy by one cycle
    property p_mix_ab; $changed(osc_phase_ab) |-> $past(mixer_ab_resync); endproperty
    a_mix_ab: assert property (p_mix_ab) else $error("mixer ab not resynced");
    property p_mix_cd; $changed(osc_phase_cd) |-> $past(mixer_cd_resync); endproperty
    a_mix_cd: assert property (p_mix_cd) else $error("mixer cd not resynced");
    property p_frq_ab; $changed(osc_freq_word_ab[31:16]) |-> $stable(osc_freq_word_ab[15:0]);
    endproperty
    a_frq_ab: assert property (p_frq_ab) else $error("ab word halves moved together");
    property p_frq_cd; $changed(osc_freq_word_cd[31:16]) |-> $stable(osc_freq_word_cd[15:0]);
    endproperty
    a_frq_cd: assert property (p_frq_cd) else $error("cd word halves moved together");
    property p_nco; nco_acc_resync |-> $past(sync_in, 2) ##1 !nco_acc_resync; endproperty
    a_nco: assert property (p_nco) else $error("nco resync without sync edge");
    property p_ndiv; pll_ndiv_reset |=> !pll_ndiv_reset; endproperty
    a_ndiv: assert property (p_ndiv) else $error("divider reset too long");
    property p_pll; $changed(pll_enable) |-> !sif_sen_n; endproperty
    a_pll: assert property (p_pll) else $error("pll enable moved outside a frame");
    property p_shut; (converter_clk_lost || data_clk_lost || fifo_collision)
        |-> ##[1:3] !outputs_on; endproperty
    a_shut: assert property (p_shut) else $error("outputs not shut off");
endmodule // dac_cfg_checker

bind dac_startup_config_sync dac_cfg_checker u_chk (
    .mclk(mclk), .nrst(nrst), .sif_sen_n(sif_sen_n), .sync_in(sync_in),
    .converter_clk_lost(converter_clk_lost), .data_clk_lost(data_clk_lost),
    .fifo_collision(fifo_collision), .outputs_on(outputs_on),
    .offset_ab_resync(offset_ab_resync), .offset_cd_resync(offset_cd_resync),
    .corr_ab_resync(corr_ab_resync), .corr_cd_resync(corr_cd_resync),
    .mixer_ab_resync(mixer_ab_resync), .mixer_cd_resync(mixer_cd_resync),
    .nco_acc_resync(nco_acc_resync), .pll_ndiv_reset(pll_ndiv_reset),
    .pll_enable(pll_enable), .osc_freq_word_ab(osc_freq_word_ab),
    .osc_freq_word_cd(osc_freq_word_cd), .osc_phase_ab(osc_phase_ab),
    .osc_phase_cd(osc_phase_cd));

// ==== test/sif_host.sv ====
// host model on the serial configuration port
// assumes mclk at 50 MHz; sclk half period is 5 mclk and idles low
`timescale 1ns/1ps
module sif_host (
    input  wire mclk,
    input  wire sif_sdio_out,
    input  wire sif_sdio_oe,
    output reg  sif_sclk,
    output reg  sif_sen_n,
    output wire sif_sdio_in
);
    reg drv_r;
    reg bit_r;
    // a released line shows the inverse of the last bit, never a held copy
    assign sif_sdio_in = sif_sdio_oe ? sif_sdio_out : (drv_r ? bit_r : ~bit_r);
    initial begin
        sif_sclk = 1'b0;
        sif_sen_n = 1'b1;
        drv_r = 1'b0;
        bit_r = 1'b0;
    end
    // whole frame, msb first; the caller waits for it before the next
    task xfer(input [23:0] f, output [15:0] rdata);
        integer i;
        begin
            rdata = 16'h0000;
            @(posedge mclk);
            sif_sen_n <= 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                if (f[23] && i < 16) drv_r <= 1'b0;
                else begin
                    drv_r <= 1'b1;
                    bit_r <= f[i];
                end
                repeat (5) @(posedge mclk);
                sif_sclk <= 1'b1;
                rdata = {rdata[14:0], sif_sdio_in};
                repeat (5) @(posedge mclk);
                sif_sclk <= 1'b0;
            end
            repeat (8) @(posedge mclk);
            sif_sen_n <= 1'b1;
            drv_r <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask
endmodule // sif_host

// ==== test/testbench.sv ====
// self-checking bench for the configuration bank
// assumes sif_host on the serial port and the checker bound to the design
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
    failures = failures + 1; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    reg         mclk;
    reg         nrst;
    reg         txen;
    reg         sync_in;
    reg  [6:0]  ev;
    reg  [7:0]  seen;
    reg  [15:0] sel;
    reg  [15:0] rd;
    reg  [15:0] rnd;
    reg  [15:0] ofs_b;
    reg  [31:0] w;
    integer     failures;
    integer     checked;
    integer     cyc;
    integer     i;
    wire        sclk, sen_n, sdi, sdo, sdoe, alarm_out, outputs_on, pll_enable;
    wire [7:0]  pl;
    wire [31:0] fw_ab, fw_cd;
    wire [15:0] ph_ab, ph_cd, fob;
    dac_startup_config_sync uut (.mclk(mclk), .nrst(nrst), .sif_sclk(sclk),
        .sif_sen_n(sen_n), .sif_sdio_in(sdi), .sif_sdio_out(sdo), .sif_sdio_oe(sdoe),
        .transmit_enable_pin(txen), .sync_in(sync_in), .converter_clk_lost(ev[0]),
        .data_clk_lost(ev[1]), .fifo_collision(ev[2]), .fifo_one_away(ev[3]),
        .fifo_two_away(ev[4]), .pll_unlocked(ev[5]), .parity_error(ev[6]),
        .alarm_out(alarm_out), .outputs_on(outputs_on), .offset_ab_resync(pl[0]),
        .offset_cd_resync(pl[1]), .corr_ab_resync(pl[2]), .corr_cd_resync(pl[3]),
        .mixer_ab_resync(pl[4]), .mixer_cd_resync(pl[5]), .nco_acc_resync(pl[6]),
        .pll_ndiv_reset(pl[7]), .pll_enable(pll_enable), .osc_freq_word_ab(fw_ab),
        .osc_freq_word_cd(fw_cd), .osc_phase_ab(ph_ab), .osc_phase_cd(ph_cd),
        .fifo_offset_offset_b(fob));
    sif_host host (.mclk(mclk), .sif_sdio_out(sdo), .sif_sdio_oe(sdoe), .sif_sclk(sclk),
        .sif_sen_n(sen_n), .sif_sdio_in(sdi));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        seen <= seen | pl;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            if (failures == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    function [31:0] f_word(input [63:0] fout, input [63:0] fclk);
        f_word = (fout << 32) / fclk;
    endfunction
    function [7:0] exp_p(input [6:0] a, input [15:0] d);
        begin
            exp_p = {2'b00, a == 7'h13, a == 7'h12, a == 7'h11 & sel[0],
                     a == 7'h10 & sel[4], a == 7'h0a & sel[8], a == 7'h08 & sel[12]};
            // serial trigger fires every block whose select nibble has bit3 set
            if (a == 7'h1f && d[1]) exp_p[3:0] = {sel[3], sel[7], sel[11], sel[15]};
        end
    endfunction
    function [15:0] st(input integer k);
        case (k)
            0: st = 16'h0400;
            1: st = 16'h0200;
            2: st = 16'h2000;
            3: st = 16'h1000;
            4: st = 16'h0800;
            5: st = 16'h0020;
            default: st = 16'h0010;
        endcase
    endfunction
    task rc(input [6:0] a, input [15:0] e);
        begin
            host.xfer({1'b1, a, 16'h0000}, rd);
            `CHK("read", e, rd)
        end
    endtask
    task wc(input [6:0] a, input [15:0] d);
        reg [7:0] e;
        begin
            e = exp_p(a, d);
            @(negedge mclk) seen = 8'h00;
            host.xfer({1'b0, a, d}, rd);
            `CHK("resync", e, seen)
            if (a == 7'h1e) sel = d;
            rc(a, d);
        end
    endtask
    task ps(input [1:0] e);
        begin
            @(negedge mclk) seen = 8'h00;
            @(posedge mclk) sync_in <= 1'b1;
            repeat (12) @(posedge mclk);
            sync_in <= 1'b0;
            repeat (4) @(posedge mclk);
            `CHK("sync", e, seen[7:6])
        end
    endtask
    initial begin
        nrst = 1'b0;
        txen = 1'b0;
        sync_in = 1'b0;
        ev = 7'h00;
        seen = 8'h00;
        sel = 16'h0000;
        failures = 0;
        checked = 0;
        cyc = 0;
        rnd = 16'($urandom(32'h9923));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK("alarm idle", 1'b1, alarm_out)
        rc(7'h00, 16'h049c);
        rc(7'h01, 16'h040e);
        rc(7'h02, 16'h7000);
        rc(7'h03, 16'hf000);
        rc(7'h07, 16'hffff);
        rc(7'h1e, 16'h0000);
        ps(2'b00);
        wc(7'h00, 16'hf19f);
        wc(7'h01, 16'h040e);
        wc(7'h02, 16'h7052);
        wc(7'h03, 16'ha000);
        wc(7'h07, 16'hd8ff);
        for (i = 8; i < 20; i = i + 1) begin
            rnd = 16'($urandom);
            if (i == 9) ofs_b = rnd;
            wc(i[6:0], rnd);
        end
        `CHK("fifo ofs b", ofs_b, fob)
        `CHK("osc ph cd", rnd, ph_cd)
        w = f_word(64'd122880, 64'd1474560);
        wc(7'h14, w[15:0]);
        `CHK("ab low half", {16'h0000, w[15:0]}, fw_ab)
        wc(7'h15, w[31:16]);
        `CHK("ab word", w, fw_ab)
        wc(7'h16, w[15:0]);
        wc(7'h17, w[31:16]);
        `CHK("cd word", w, fw_cd)
        wc(7'h18, 16'h2c50);
        `CHK("pll on", 1'b1, pll_enable)
        wc(7'h19, 16'h20f4);
        wc(7'h1a, 16'h7010);
        wc(7'h1b, 16'h0800);
        wc(7'h1e, 16'h9999);
        for (i = 0; i < 4; i = i + 1) begin
            rnd = 16'($urandom);
            wc(i < 2 ? 7'h08 + 2 * i : 7'h0e + i, rnd);
        end
        `CHK("osc ph ab", 1'b1, ph_ab !== 16'h0000)
        ps(2'b11);
        wc(7'h1f, 16'h4442);
        wc(7'h1f, 16'h4448);
        wc(7'h18, 16'h2450);
        ps(2'b01);
        host.xfer({1'b0, 7'h1c, 16'hffff}, rd);
        rc(7'h1c, 16'h0000);
        host.xfer({1'b0, 7'h05, 16'h0000}, rd);
        rc(7'h05, 16'h0000);
        txen <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK("outputs on", 1'b1, outputs_on)
        for (i = 0; i < 7; i = i + 1) begin
            @(posedge mclk) ev <= 7'h01 << i;
            @(posedge mclk) ev <= 7'h00;
            repeat (8) @(posedge mclk);
            `CHK("alarm pin", i > 2, alarm_out)
            `CHK("shut off", i > 2, outputs_on)
            host.xfer({1'b1, 7'h05, 16'h0000}, rd);
            `CHK("status", st(i), rd & 16'h3e30)
            host.xfer({1'b0, 7'h05, 16'h0000}, rd);
            `CHK("cleared", 2'b11, {alarm_out, outputs_on})
        end
        end_of_test;
    end
endmodule // testbench

// ==== verilog/dac_cfg_map.vh ====
// register offsets, field positions, reset values and frame layout of the
// converter configuration bank; included by dac_startup_config_sync.v only.
//
// Behaviour
// - writing offset_a (0x08) re-syncs the A/B offset correction block.
// - writing offset_c (0x0A) re-syncs the C/D offset correction block.
// - writing phase_corr_ab (0x10) re-syncs the A/B gain-and-phase correction block.
// - writing phase_corr_cd (0x11) re-syncs the C/D gain-and-phase correction block.
// - 0x12 holds the A/B oscillator phase offset; writing it re-syncs A/B mixer.
// - 0x13 holds the C/D oscillator phase offset; writing it re-syncs C/D mixer.
// - A/B 32-bit frequency word: low half at 0x14, high half 0x15.
// - C/D 32-bit frequency word: low half at 0x16, high half 0x17.
// - oscillator accumulator re-syncs on a rising edge of the sync input.
// - 0x1E picks serial sync trigger or write auto-sync per correction block.
// - 0x09 holds both the fifo offset and the channel B offset.
// - enables in 0x02 shut outputs off on clock loss or fifo collision.
// - mask in 0x07 gates alarms to the alarm output; 0xD8FF passes four (bits 13, 10, 9, 8).
// - 0x01 enables parity checking and fifo two-away, one-away, collision alarms.
// - 0x18 enables the pll and its N-divider sync.
// - writing zero to 0x05 clears alarms; reading returns the alarm state.
`ifndef DAC_CFG_MAP_VH
`define DAC_CFG_MAP_VH

`define A_CTRL      5'h00
`define A_PARITY    5'h01
`define A_SHUTOFF   5'h02
`define A_CURRENT   5'h03
`define A_IOTEST    5'h04
`define A_ALARM     5'h05
`define A_TEMP      5'h06
`define A_MASK      5'h07
`define A_OFS_A     5'h08
`define A_OFS_B     5'h09
`define A_OFS_C     5'h0a
`define A_OFS_D     5'h0b
`define A_PH_AB     5'h10
`define A_PH_CD     5'h11
`define A_OSC_PH_AB 5'h12
`define A_OSC_PH_CD 5'h13
`define A_FRQ_AB_LO 5'h14
`define A_FRQ_AB_HI 5'h15
`define A_FRQ_CD_LO 5'h16
`define A_FRQ_CD_HI 5'h17
`define A_PLL       5'h18
`define A_VCO       5'h1a
`define A_REFSEL    5'h1b
`define A_SYNC_SEL  5'h1e
`define A_SYNC_CTRL 5'h1f
`define A_HOLE_LO   5'h1c
`define A_HOLE_HI   5'h1d

`define RST_CTRL    16'h049c
`define RST_PARITY  16'h040e
`define RST_SHUTOFF 16'h7000
`define RST_CURRENT 16'hf000
`define RST_MASK    16'hffff
`define RST_OTHER   16'h0000

// control fields
`define B_ALARM_ENA   4
`define B_ALARM_POL   3
`define B_PARITY_ENA  10
`define B_AL_2AWAY    3
`define B_AL_1AWAY    2
`define B_AL_COLL     1
`define B_SO_DACCLK   14
`define B_SO_DATACLK  13
`define B_SO_COLL     12
`define B_NCO_ENA     4
`define B_TXENABLE    0
`define B_PLL_NDIVSYN 11
`define B_PLL_ENA     10
`define B_SIF_SYNC    1
// per-block sync select: serial trigger bit and auto-sync bit
`define B_SEL_OFS_AB_SER 15
`define B_SEL_OFS_AB_AUTO 12
`define B_SEL_OFS_CD_SER 11
`define B_SEL_OFS_CD_AUTO 8
`define B_SEL_COR_AB_SER 7
`define B_SEL_COR_AB_AUTO 4
`define B_SEL_COR_CD_SER 3
`define B_SEL_COR_CD_AUTO 0

// alarm status bits
`define B_ST_COLL     13
`define B_ST_1AWAY    12
`define B_ST_2AWAY    11
`define B_ST_DACCLK   10
`define B_ST_DATACLK  9
`define B_ST_OUTGONE  8
`define B_ST_PLL      5
`define B_ST_PARITY   4

// serial frame: 1 direction bit, 7 address bits, 16 data bits
`define FRAME_LAST    5'd23
`define FRAME_ADDR    5'd7
`define ADDR_W        7

// pin idle levels in synchroniser order; only the select (bit 1) idles high
`define PIN_IDLE      5'h02

`endif

// ==== verilog/dac_startup_config_sync.v ====
// configuration register bank of a four-channel converter with its serial
// configuration port, alarm collection, output shut-off and block re-sync.
// assumes pins arrive asynchronous to mclk and sclk is well below mclk / 8.
`timescale 1ns/1ps
`include "dac_cfg_map.vh"

module dac_startup_config_sync (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        sif_sclk,
    input  wire        sif_sen_n,
    input  wire        sif_sdio_in,
    output reg         sif_sdio_out,
    output reg         sif_sdio_oe,
    input  wire        transmit_enable_pin,
    input  wire        sync_in,
    input  wire        converter_clk_lost,
    input  wire        data_clk_lost,
    input  wire        fifo_collision,
    input  wire        fifo_one_away,
    input  wire        fifo_two_away,
    input  wire        pll_unlocked,
    input  wire        parity_error,
    output reg         alarm_out,
    output reg         outputs_on,
    output reg         offset_ab_resync,
    output reg         offset_cd_resync,
    output reg         corr_ab_resync,
    output reg         corr_cd_resync,
    output reg         mixer_ab_resync,
    output reg         mixer_cd_resync,
    output reg         nco_acc_resync,
    output reg         pll_ndiv_reset,
    output reg         pll_enable,
    output reg  [31:0] osc_freq_word_ab,
    output reg  [31:0] osc_freq_word_cd,
    output reg  [15:0] osc_phase_ab,
    output reg  [15:0] osc_phase_cd,
    output reg  [15:0] fifo_offset_offset_b
);

// ----------------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------------
function [15:0] reset_value;
    input [4:0] a;
    begin
        case (a)
            `A_CTRL:    reset_value = `RST_CTRL;
            `A_PARITY:  reset_value = `RST_PARITY;
            `A_SHUTOFF: reset_value = `RST_SHUTOFF;
            `A_CURRENT: reset_value = `RST_CURRENT;
            `A_MASK:    reset_value = `RST_MASK;
            default:    reset_value = `RST_OTHER;
        endcase
    end
endfunction

// storage exists for 0x00-0x1f except the 0x1c/0x1d hole and alarm/iotest/temp which are special
function is_mapped;
    input [6:0] a;
    begin
        is_mapped = (a[6:5] == 2'b00) && (a[4:0] != `A_HOLE_LO) && (a[4:0] != `A_HOLE_HI);
    end
endfunction

function is_storage;
    input [6:0] a;
    begin
        is_storage = is_mapped(a) && (a[4:0] != `A_ALARM) && (a[4:0] != `A_IOTEST)
                     && (a[4:0] != `A_TEMP);
    end
endfunction

// ----------------------------------------------------------------------------
// pin synchronisers: three stages, level moves once stages two and three agree
// ----------------------------------------------------------------------------
localparam NPIN = 5;
wire [NPIN-1:0] pin_raw = {sync_in, transmit_enable_pin, sif_sdio_in, sif_sen_n, sif_sclk};
reg  [NPIN-1:0] pin_s1_r;
reg  [NPIN-1:0] pin_s2_r;
reg  [NPIN-1:0] pin_s3_r;
reg  [NPIN-1:0] pin_lvl_r;
wire [NPIN-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
wire [NPIN-1:0] pin_nxt   = (pin_agree & pin_s3_r) | (~pin_agree & pin_lvl_r);
wire [NPIN-1:0] pin_rise  = pin_nxt & ~pin_lvl_r;
wire [NPIN-1:0] pin_fall  = ~pin_nxt & pin_lvl_r;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        // every stage starts at the idle levels so no false frame follows reset
        pin_s1_r  <= `PIN_IDLE;
        pin_s2_r  <= `PIN_IDLE;
        pin_s3_r  <= `PIN_IDLE;
        pin_lvl_r <= `PIN_IDLE;
    end else begin
        pin_s1_r  <= pin_raw;
        pin_s2_r  <= pin_s1_r;
        pin_s3_r  <= pin_s2_r;
        pin_lvl_r <= pin_nxt;
    end
end

wire sclk_rise = pin_rise[0];
wire sclk_fall = pin_fall[0];
wire sen_n_lvl = pin_nxt[1];
wire sdio_lvl  = pin_nxt[2];
wire transmit_enable_pin_lvl = pin_lvl_r[3];
wire sync_rise = pin_rise[4];

// ----------------------------------------------------------------------------
// serial frame engine
// ----------------------------------------------------------------------------
reg  [4:0]  bit_cnt_r;
reg  [23:0] shift_in_r;
reg  [15:0] shift_out_r;
reg         wr_pulse_r;
reg  [6:0]  wr_addr_r;
reg  [15:0] wr_data_r;
reg  [15:0] regs_r [0:31];
reg  [15:0] alarms_r;
wire [23:0] shift_in_nxt = {shift_in_r[22:0], sdio_lvl};
wire [6:0]  frame_addr   = shift_in_nxt[6:0];
wire        frame_read   = shift_in_nxt[7];
reg  [15:0] read_word;

always @* begin
    read_word = 16'h0000;
    if (frame_addr == {2'b00, `A_ALARM})
        read_word = alarms_r;
    else if (is_storage(frame_addr))
        read_word = regs_r[frame_addr[4:0]];
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        bit_cnt_r    <= 5'd0;
        shift_in_r   <= 24'h000000;
        shift_out_r  <= 16'h0000;
        sif_sdio_out <= 1'b0;
        sif_sdio_oe  <= 1'b0;
        wr_pulse_r   <= 1'b0;
        wr_addr_r    <= 7'h00;
        wr_data_r    <= 16'h0000;
    end else begin
        wr_pulse_r <= 1'b0;
        if (sen_n_lvl) begin
            // deselect aborts a partial frame without committing anything
            bit_cnt_r   <= 5'd0;
            sif_sdio_oe <= 1'b0;
        end else if (sclk_rise) begin
            shift_in_r <= shift_in_nxt;
            if (bit_cnt_r == `FRAME_ADDR && frame_read)
                shift_out_r <= read_word;
            if (bit_cnt_r == `FRAME_LAST) begin
                bit_cnt_r <= 5'd0;
                if (!shift_in_nxt[23]) begin
                    wr_pulse_r <= 1'b1;
                    wr_addr_r  <= shift_in_nxt[22:16];
                    wr_data_r  <= shift_in_nxt[15:0];
                end
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'd1;
            end
        end else if (sclk_fall && bit_cnt_r > `FRAME_ADDR && shift_in_r[bit_cnt_r - 5'd1]) begin
            // read data changes on the falling edge, msb first
            sif_sdio_oe  <= 1'b1;
            sif_sdio_out <= shift_out_r[15];
            shift_out_r  <= {shift_out_r[14:0], 1'b0};
        end
    end
end

// ----------------------------------------------------------------------------
// register file
// ----------------------------------------------------------------------------
wire wr_store = wr_pulse_r && is_storage(wr_addr_r);
integer i;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        for (i = 0; i < 32; i = i + 1)
            regs_r[i] <= reset_value(i[4:0]);
    end else if (wr_store) begin
        regs_r[wr_addr_r[4:0]] <= wr_data_r;
    end
end

wire [15:0] ctrl_r     = regs_r[`A_CTRL];
wire [15:0] parity_r   = regs_r[`A_PARITY];
wire [15:0] shutoff_r  = regs_r[`A_SHUTOFF];
wire [15:0] current_r  = regs_r[`A_CURRENT];
wire [15:0] mask_r     = regs_r[`A_MASK];
wire [15:0] pll_r      = regs_r[`A_PLL];
wire [15:0] sync_sel_r = regs_r[`A_SYNC_SEL];
wire [15:0] sync_ctl_r = regs_r[`A_SYNC_CTRL];

function wr_hit;
    input       pulse;
    input [6:0] waddr;
    input [4:0] target;
    begin
        wr_hit = pulse && (waddr == {2'b00, target});
    end
endfunction

// ----------------------------------------------------------------------------
// alarms, shut-off and alarm pin
// ----------------------------------------------------------------------------
reg         shut_r;
reg  [15:0] alarm_evt;
wire        alarm_clr = wr_hit(wr_pulse_r, wr_addr_r, `A_ALARM);

// shut-off holds until the causing alarm is cleared by software
wire shut_nxt = (alarms_r[`B_ST_DACCLK]  && shutoff_r[`B_SO_DACCLK])
             || (alarms_r[`B_ST_DATACLK] && shutoff_r[`B_SO_DATACLK])
             || (alarms_r[`B_ST_COLL]    && shutoff_r[`B_SO_COLL]);

always @* begin
    alarm_evt = 16'h0000;
    alarm_evt[`B_ST_COLL]    = fifo_collision && parity_r[`B_AL_COLL];
    alarm_evt[`B_ST_1AWAY]   = fifo_one_away && parity_r[`B_AL_1AWAY];
    alarm_evt[`B_ST_2AWAY]   = fifo_two_away && parity_r[`B_AL_2AWAY];
    alarm_evt[`B_ST_PARITY]  = parity_error && parity_r[`B_PARITY_ENA];
    alarm_evt[`B_ST_DACCLK]  = converter_clk_lost;
    alarm_evt[`B_ST_DATACLK] = data_clk_lost;
    alarm_evt[`B_ST_PLL]     = pll_unlocked && pll_r[`B_PLL_ENA];
    // a stale shut-off must not re-arm its own flag across the clearing write
    alarm_evt[`B_ST_OUTGONE] = shut_r && shut_nxt && !alarm_clr;
end

wire masked_any = |(alarms_r & ~mask_r);

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        alarms_r   <= 16'h0000;
        shut_r     <= 1'b0;
        alarm_out  <= 1'b0;
        outputs_on <= 1'b0;
    end else begin
        // a new event wins over a clear in the same cycle
        if (alarm_clr)
            alarms_r <= (alarms_r & wr_data_r) | alarm_evt;
        else
            alarms_r <= alarms_r | alarm_evt;
        shut_r     <= shut_nxt;
        alarm_out  <= (masked_any && ctrl_r[`B_ALARM_ENA]) ^ ctrl_r[`B_ALARM_POL];
        outputs_on <= (transmit_enable_pin_lvl || current_r[`B_TXENABLE]) && !shut_nxt;
    end
end

// ----------------------------------------------------------------------------
// re-sync pulses and configuration outputs
// ----------------------------------------------------------------------------
reg  sif_sync_q_r;
wire sif_sync_rise = sync_ctl_r[`B_SIF_SYNC] && !sif_sync_q_r;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        sif_sync_q_r         <= 1'b0;
        offset_ab_resync     <= 1'b0;
        offset_cd_resync     <= 1'b0;
        corr_ab_resync       <= 1'b0;
        corr_cd_resync       <= 1'b0;
        mixer_ab_resync      <= 1'b0;
        mixer_cd_resync      <= 1'b0;
        nco_acc_resync       <= 1'b0;
        pll_ndiv_reset       <= 1'b0;
        pll_enable           <= 1'b0;
        osc_freq_word_ab     <= 32'h00000000;
        osc_freq_word_cd     <= 32'h00000000;
        osc_phase_ab         <= 16'h0000;
        osc_phase_cd         <= 16'h0000;
        fifo_offset_offset_b <= 16'h0000;
    end else begin
        sif_sync_q_r <= sync_ctl_r[`B_SIF_SYNC];
        offset_ab_resync <= (wr_hit(wr_pulse_r, wr_addr_r, `A_OFS_A)
                             && sync_sel_r[`B_SEL_OFS_AB_AUTO])
                         || (sif_sync_rise && sync_sel_r[`B_SEL_OFS_AB_SER]);
        offset_cd_resync <= (wr_hit(wr_pulse_r, wr_addr_r, `A_OFS_C)
                             && sync_sel_r[`B_SEL_OFS_CD_AUTO])
                         || (sif_sync_rise && sync_sel_r[`B_SEL_OFS_CD_SER]);
        corr_ab_resync   <= (wr_hit(wr_pulse_r, wr_addr_r, `A_PH_AB)
                             && sync_sel_r[`B_SEL_COR_AB_AUTO])
                         || (sif_sync_rise && sync_sel_r[`B_SEL_COR_AB_SER]);
        corr_cd_resync   <= (wr_hit(wr_pulse_r, wr_addr_r, `A_PH_CD)
                             && sync_sel_r[`B_SEL_COR_CD_AUTO])
                         || (sif_sync_rise && sync_sel_r[`B_SEL_COR_CD_SER]);
        mixer_ab_resync  <= wr_hit(wr_pulse_r, wr_addr_r, `A_OSC_PH_AB);
        mixer_cd_resync  <= wr_hit(wr_pulse_r, wr_addr_r, `A_OSC_PH_CD);
        nco_acc_resync   <= sync_rise && shutoff_r[`B_NCO_ENA];
        pll_ndiv_reset   <= sync_rise && pll_r[`B_PLL_NDIVSYN];
        pll_enable       <= pll_r[`B_PLL_ENA];
        osc_phase_ab     <= regs_r[`A_OSC_PH_AB];
        osc_phase_cd     <= regs_r[`A_OSC_PH_CD];
        osc_freq_word_ab <= {regs_r[`A_FRQ_AB_HI], regs_r[`A_FRQ_AB_LO]};
        osc_freq_word_cd <= {regs_r[`A_FRQ_CD_HI], regs_r[`A_FRQ_CD_LO]};
        fifo_offset_offset_b <= regs_r[`A_OFS_B];
    end
end

endmodule // dac_startup_config_sync
